// ---- rtl/urc_serial_ctrl.sv ----
// Purpose: Asynchronous serial transmitter/receiver control and status with APB access.
// Assumes: Zero-wait APB slave; rx pin is asynchronous to i_mclk.
// Notes: One block slot; direction chosen by the function register.
`timescale 1ns/1ps
// Behaviour
// - UART function code makes control register receiver/transmitter status
// - Parity type bit: clear even, set odd
// - Parity enable bit adds parity bit per frame
// - Transmitter runs only while enable set
// - Receiver runs only while enable set
// - Parity error flag set, cleared by control read
// - Overrun flag on unread buffer, cleared by read
// - Framing error on low stop, cleared by read
// - Receive active from start bit to stop sample
// - Receive full on load, interrupts, cleared by buffer read
// - Transmit empty one at reset/disable, cleared on write
// - Transmit complete after stop, cleared by control read
module urc_serial_ctrl
   import urc_pkg::*;
#(
   parameter logic [7:0] CTRL_IDX = IDX_CTRL_A
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [DATA_W-1:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_rx_pin,
   output logic o_tx_pin,
   output logic o_irq
);

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      return a == reg_addr(idx);
   endfunction : hit

   // Pin synchroniser
   logic rx_meta_q, rx_sync_q;
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
      end else begin
         rx_meta_q <= i_rx_pin;
         rx_sync_q <= rx_meta_q;
      end
   end

   // Bus decode
   logic setup, access, wr0, wr1, rd;
   logic hit_ctrl, hit_func, hit_txbuf, hit_rxbuf, hit_baud, hit_ist, hit_iclr, hit_ien, mapped;
   assign setup = i_psel & ~i_penable;
   assign access = i_psel & i_penable;
   assign wr0 = access & i_pwrite & i_pstrb[0];
   assign wr1 = access & i_pwrite & i_pstrb[1];
   assign rd = access & ~i_pwrite;
   assign hit_ctrl = hit(i_paddr, CTRL_IDX);
   assign hit_func = hit(i_paddr, IDX_FUNC);
   assign hit_txbuf = hit(i_paddr, IDX_TXBUF);
   assign hit_rxbuf = hit(i_paddr, IDX_RXBUF);
   assign hit_baud = hit(i_paddr, IDX_BAUD);
   assign hit_ist = hit(i_paddr, IDX_IRQ_STAT);
   assign hit_iclr = hit(i_paddr, IDX_IRQ_CLR);
   assign hit_ien = hit(i_paddr, IDX_IRQ_EN);
   assign mapped = hit_ctrl | hit_func | hit_txbuf | hit_rxbuf | hit_baud | hit_ist | hit_iclr | hit_ien;

   // Configuration group
   urc_cfg_t cfg_q, cfg_d;
   urc_func_t func_q, func_d;
   logic [15:0] baud_q, baud_d;
   logic [IRQ_W-1:0] ien_q, ien_d;
   logic uart_mode, tx_on, rx_on;

   always_comb begin
      cfg_d = cfg_q;
      func_d = func_q;
      baud_d = baud_q;
      ien_d = ien_q;
      if (wr0 && hit_ctrl) begin
         cfg_d = i_pwdata[CFG_W-1:0];
      end
      if (wr0 && hit_func) begin
         func_d = i_pwdata[3:0];
      end
      if (wr0 && hit_baud) begin
         baud_d[7:0] = i_pwdata[7:0];
      end
      if (wr1 && hit_baud) begin
         baud_d[15:8] = i_pwdata[15:8];
      end
      if (wr0 && hit_ien) begin
         ien_d = i_pwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         cfg_q <= CTRL_RST;
         func_q <= FUNC_RST;
         baud_q <= BAUD_RST;
         ien_q <= IRQ_EN_RST;
      end else begin
         cfg_q <= cfg_d;
         func_q <= func_d;
         baud_q <= baud_d;
         ien_q <= ien_d;
      end
   end

   assign uart_mode = (func_q.fn == FN_UART);
   assign tx_on = uart_mode & ~func_q.dir_rx & cfg_q.enable;
   assign rx_on = uart_mode & func_q.dir_rx & cfg_q.enable;

   // Receiver
   logic rx_busy, rx_done;
   urc_rx_res_t rx_res;
   urc_rx_frame u_rx (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_en(rx_on),
      .i_cfg(cfg_q),
      .i_div(baud_q),
      .i_rxd(rx_sync_q),
      .o_busy(rx_busy),
      .o_done(rx_done),
      .o_res(rx_res)
   );

   // Transmitter group
   urc_frame_st_t tx_st_q, tx_st_d;
   logic [15:0] tx_cnt_q, tx_cnt_d;
   logic [2:0] tx_bit_q, tx_bit_d;
   logic [7:0] tx_sh_q, tx_sh_d, tx_byte_q, tx_byte_d;
   logic tx_par_q, tx_par_d, tx_pin_q, tx_pin_d;
   logic tx_tick, tx_load, tx_cmpl_ev;
   logic tx_full_q, rx_full_q;
   logic [7:0] txbuf_q;

   assign tx_tick = (tx_cnt_q == 16'h0000);
   assign tx_load = tx_on & (tx_st_q == FR_IDLE) & tx_full_q;
   assign tx_cmpl_ev = tx_on & (tx_st_q == FR_STOP) & tx_tick;

   always_comb begin
      tx_st_d = tx_st_q;
      tx_cnt_d = tx_cnt_q;
      tx_bit_d = tx_bit_q;
      tx_sh_d = tx_sh_q;
      tx_byte_d = tx_byte_q;
      tx_par_d = tx_par_q;
      tx_pin_d = tx_pin_q;
      if (!tx_on) begin
         tx_st_d = FR_IDLE;
         tx_pin_d = 1'b1;
      end else begin
         if (tx_st_q != FR_IDLE && !tx_tick) begin
            tx_cnt_d = tx_cnt_q - 16'h0001;
         end
         unique case (tx_st_q)
            FR_IDLE: begin
               if (tx_load) begin
                  tx_sh_d = txbuf_q;
                  tx_byte_d = txbuf_q;
                  tx_par_d = (^txbuf_q) ^ cfg_q.parity_odd;
                  tx_pin_d = 1'b0;
                  tx_cnt_d = baud_q;
                  tx_st_d = FR_START;
               end
            end
            FR_START: begin
               if (tx_tick) begin
                  tx_pin_d = tx_sh_q[0];
                  tx_sh_d = {1'b0, tx_sh_q[7:1]};
                  tx_bit_d = 3'h0;
                  tx_cnt_d = baud_q;
                  tx_st_d = FR_DATA;
               end
            end
            FR_DATA: begin
               if (tx_tick) begin
                  tx_cnt_d = baud_q;
                  if (tx_bit_q == LAST_BIT) begin
                     tx_pin_d = cfg_q.parity_en ? tx_par_q : 1'b1;
                     tx_st_d = cfg_q.parity_en ? FR_PARITY : FR_STOP;
                  end else begin
                     tx_pin_d = tx_sh_q[0];
                     tx_sh_d = {1'b0, tx_sh_q[7:1]};
                     tx_bit_d = tx_bit_q + 3'h1;
                  end
               end
            end
            FR_PARITY: begin
               if (tx_tick) begin
                  tx_pin_d = 1'b1;
                  tx_cnt_d = baud_q;
                  tx_st_d = FR_STOP;
               end
            end
            FR_STOP: begin
               if (tx_tick) begin
                  tx_st_d = FR_IDLE;
               end
            end
            default: tx_st_d = FR_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         tx_st_q <= FR_IDLE;
         tx_cnt_q <= 16'h0000;
         tx_bit_q <= 3'h0;
         tx_sh_q <= 8'h00;
         tx_byte_q <= 8'h00;
         tx_par_q <= 1'b0;
         tx_pin_q <= 1'b1;
      end else begin
         tx_st_q <= tx_st_d;
         tx_cnt_q <= tx_cnt_d;
         tx_bit_q <= tx_bit_d;
         tx_sh_q <= tx_sh_d;
         tx_byte_q <= tx_byte_d;
         tx_par_q <= tx_par_d;
         tx_pin_q <= tx_pin_d;
      end
   end

   // Status group; every flag: set beats clear
   logic rx_full_d, perr_q, perr_d, ovr_q, ovr_d, ferr_q, ferr_d, tx_full_d, txcmpl_q, txcmpl_d;
   logic [7:0] rxbuf_q, rxbuf_d, txbuf_d;
   logic [IRQ_W-1:0] ist_q, ist_d, ev;
   logic rd_ctrl, rd_rxbuf, wr_txbuf;
   logic [DATA_W-1:0] prdata_q;

   assign rd_ctrl = rd & hit_ctrl;
   assign rd_rxbuf = rd & hit_rxbuf;
   assign wr_txbuf = wr0 & hit_txbuf & tx_on;

   always_comb begin
      ev = '0;
      ev[IRQ_RXFULL] = rx_done;
      ev[IRQ_TXEMPTY] = tx_load;
      ev[IRQ_TXCMPL] = tx_cmpl_ev;
      ev[IRQ_ERR] = rx_done & (rx_res.parity_err | rx_res.frame_err | (rx_full_q & ~rd_rxbuf));
      // Read-clear drops only flags whose bit read as one; FERR_BIT and TXCMPL_BIT share bit 5
      perr_d = (perr_q & ~(rd_ctrl & prdata_q[PERR_BIT])) | (rx_done & rx_res.parity_err);
      ovr_d = (ovr_q & ~(rd_ctrl & prdata_q[OVR_BIT])) | (rx_done & rx_full_q & ~rd_rxbuf);
      ferr_d = (ferr_q & ~(rd_ctrl & prdata_q[FERR_BIT])) | (rx_done & rx_res.frame_err);
      rx_full_d = (rx_full_q & ~rd_rxbuf) | rx_done;
      rxbuf_d = rx_done ? rx_res.data : rxbuf_q;
      tx_full_d = tx_on & ((tx_full_q & ~tx_load) | wr_txbuf);
      txbuf_d = wr_txbuf ? i_pwdata[7:0] : txbuf_q;
      txcmpl_d = (txcmpl_q & ~(rd_ctrl & prdata_q[TXCMPL_BIT])) | tx_cmpl_ev;
      ist_d = (ist_q & ~((wr0 && hit_iclr) ? i_pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) | ev;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         perr_q <= 1'b0;
         ovr_q <= 1'b0;
         ferr_q <= 1'b0;
         rx_full_q <= 1'b0;
         rxbuf_q <= 8'h00;
         tx_full_q <= 1'b0;
         txbuf_q <= 8'h00;
         txcmpl_q <= 1'b0;
         ist_q <= '0;
      end else begin
         perr_q <= perr_d;
         ovr_q <= ovr_d;
         ferr_q <= ferr_d;
         rx_full_q <= rx_full_d;
         rxbuf_q <= rxbuf_d;
         tx_full_q <= tx_full_d;
         txbuf_q <= txbuf_d;
         txcmpl_q <= txcmpl_d;
         ist_q <= ist_d;
      end
   end

   // Read path, captured in the setup cycle
   logic [7:0] ctrl_view;
   logic [DATA_W-1:0] prdata_d;
   logic slverr_q, slverr_d;

   always_comb begin
      ctrl_view = {5'h00, cfg_q};
      if (uart_mode && func_q.dir_rx) begin
         ctrl_view = {perr_q, ovr_q, ferr_q, rx_busy, rx_full_q, cfg_q};
      end else if (uart_mode) begin
         ctrl_view = {2'h0, txcmpl_q, ~tx_full_q, 1'b0, cfg_q};
      end
      prdata_d = prdata_q;
      slverr_d = slverr_q;
      if (setup) begin
         prdata_d = '0;
         slverr_d = ~mapped;
         if (hit_ctrl) prdata_d[7:0] = ctrl_view;
         if (hit_func) prdata_d[3:0] = func_q;
         if (hit_rxbuf) prdata_d[7:0] = rxbuf_q;
         if (hit_baud) prdata_d[15:0] = baud_q;
         if (hit_ist) prdata_d[IRQ_W-1:0] = ist_q;
         if (hit_ien) prdata_d[IRQ_W-1:0] = ien_q;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         prdata_q <= '0;
         slverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         slverr_q <= slverr_d;
      end
   end

   assign o_prdata = prdata_q;
   assign o_pslverr = slverr_q;
   assign o_pready = 1'b1;
   assign o_tx_pin = tx_pin_q;
   assign o_irq = |(ist_q & ien_q);

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);

   a_ctrl_mode_view: assert property (
      setup && !i_pwrite && hit_ctrl && !uart_mode |=> o_prdata[7:3] == 5'h00)
      else $error("control view shows status outside serial mode");
   a_tx_parity_bit: assert property (
      tx_st_q == FR_PARITY |-> o_tx_pin == ((^tx_byte_q) ^ cfg_q.parity_odd))
      else $error("transmitted parity bit wrong");
   a_tx_no_parity: assert property (
      tx_on && tx_st_q == FR_DATA && tx_tick && tx_bit_q == LAST_BIT && !cfg_q.parity_en
      |=> tx_st_q == FR_STOP && o_tx_pin)
      else $error("parity bit sent while parity disabled");
   a_tx_off_idle: assert property (
      !tx_on |=> tx_st_q == FR_IDLE && o_tx_pin)
      else $error("transmitter active while disabled");
   a_rx_off_idle: assert property (
      !rx_on |=> !rx_busy)
      else $error("receiver active while disabled");
   a_perr_set: assert property (
      rx_done && rx_res.parity_err |=> perr_q && rx_full_q)
      else $error("parity error not flagged");
   a_ovr_set: assert property (
      rx_done && rx_full_q && !rd_rxbuf |=> ovr_q && rx_full_q)
      else $error("overrun not flagged");
   a_ferr_clear: assert property (
      rd_ctrl && prdata_q[FERR_BIT] && uart_mode && func_q.dir_rx && !rx_done |=> !ferr_q)
      else $error("framing error not cleared by control read");
   a_rx_active_set: assert property (
      rx_on && !rx_busy && !rx_sync_q |=> rx_busy)
      else $error("start bit did not raise receive active");
   a_rxfull_clear: assert property (
      rd_rxbuf && !rx_done |=> !rx_full_q)
      else $error("receive full not cleared by buffer read");
   a_txempty_off: assert property (
      !tx_on |=> !tx_full_q)
      else $error("transmit empty not held while disabled");
   a_txcmpl_set: assert property (
      tx_cmpl_ev |=> txcmpl_q && tx_st_q == FR_IDLE)
      else $error("transmit complete not flagged after stop");
   a_cfg_only_wr: assert property (
      wr0 && hit_ctrl |=> cfg_q == $past(i_pwdata[CFG_W-1:0]))
      else $error("control write did not land in config bits");

endmodule : urc_serial_ctrl

// ---- rtl/urc_pkg.sv ----
// Purpose: Shared constants and types of the serial control and status block.
// Assumes: APB with 32-bit data; register byte address is four times the index.
// Notes: Narrow registers sit in the low bits of the word, upper bits read zero.
package urc_pkg;

   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   // Register indexes of the six block slots
   localparam logic [7:0] IDX_CTRL_A = 8'h2B;
   localparam logic [7:0] IDX_CTRL_B = 8'h2F;
   localparam logic [7:0] IDX_CTRL_C = 8'h3B;
   localparam logic [7:0] IDX_CTRL_D = 8'h3F;
   localparam logic [7:0] IDX_CTRL_E = 8'h4B;
   localparam logic [7:0] IDX_CTRL_F = 8'h4F;
   // Companion registers of this block
   localparam logic [7:0] IDX_FUNC = 8'h80;
   localparam logic [7:0] IDX_TXBUF = 8'h81;
   localparam logic [7:0] IDX_RXBUF = 8'h82;
   localparam logic [7:0] IDX_BAUD = 8'h83;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h84;
   localparam logic [7:0] IDX_IRQ_CLR = 8'h85;
   localparam logic [7:0] IDX_IRQ_EN = 8'h86;

   localparam logic [2:0] FN_UART = 3'h5;

   // Control register fields
   localparam int unsigned CFG_W = 3;
   localparam int unsigned RXFULL_BIT = 3;
   localparam int unsigned RXACT_BIT = 4;
   localparam int unsigned FERR_BIT = 5;
   localparam int unsigned OVR_BIT = 6;
   localparam int unsigned PERR_BIT = 7;
   localparam int unsigned TXEMPTY_BIT = 4;
   localparam int unsigned TXCMPL_BIT = 5;

   // Interrupt status, clear and enable layout
   localparam int unsigned IRQ_W = 4;
   localparam int unsigned IRQ_RXFULL = 0;
   localparam int unsigned IRQ_TXEMPTY = 1;
   localparam int unsigned IRQ_TXCMPL = 2;
   localparam int unsigned IRQ_ERR = 3;

   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [3:0] FUNC_RST = 4'h0;
   localparam logic [15:0] BAUD_RST = 16'h0015;
   localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h2;
   localparam logic [2:0] LAST_BIT = 3'h7;

   typedef struct packed {
      logic parity_odd;
      logic parity_en;
      logic enable;
   } urc_cfg_t;

   typedef struct packed {
      logic dir_rx;
      logic [2:0] fn;
   } urc_func_t;

   typedef struct packed {
      logic [7:0] data;
      logic parity_err;
      logic frame_err;
   } urc_rx_res_t;

   typedef enum logic [2:0] {FR_IDLE, FR_START, FR_DATA, FR_PARITY, FR_STOP} urc_frame_st_t;

   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction : reg_addr

endpackage : urc_pkg

// ---- rtl/urc_rx_frame.sv ----
// Purpose: Receive framing engine: start detect, data, parity and stop sampling.
// Assumes: i_rxd already synchronised; bit period is i_div + 1 clocks.
// Notes: Samples mid-bit after a half-period start qualification.
`timescale 1ns/1ps
module urc_rx_frame
   import urc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_en,
   input wire urc_cfg_t i_cfg,
   input wire logic [15:0] i_div,
   input wire logic i_rxd,
   output logic o_busy,
   output logic o_done,
   output urc_rx_res_t o_res
);

   urc_frame_st_t st_q, st_d;
   logic [15:0] cnt_q, cnt_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic par_q, par_d;
   logic busy_q, busy_d;
   logic done_q, done_d;
   urc_rx_res_t res_q, res_d;
   logic tick;

   assign tick = (cnt_q == 16'h0000);

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      bit_d = bit_q;
      sh_d = sh_q;
      par_d = par_q;
      busy_d = busy_q;
      done_d = 1'b0;
      res_d = res_q;
      if (!i_en) begin
         st_d = FR_IDLE;
         busy_d = 1'b0;
      end else begin
         if (st_q != FR_IDLE && !tick) begin
            cnt_d = cnt_q - 16'h0001;
         end
         unique case (st_q)
            FR_IDLE: begin
               if (!i_rxd) begin
                  st_d = FR_START;
                  cnt_d = {1'b0, i_div[15:1]};
                  busy_d = 1'b1;
               end
            end
            FR_START: begin
               if (tick) begin
                  if (i_rxd) begin
                     // Glitch, not a start bit
                     st_d = FR_IDLE;
                     busy_d = 1'b0;
                  end else begin
                     st_d = FR_DATA;
                     cnt_d = i_div;
                     bit_d = 3'h0;
                     par_d = 1'b0;
                     res_d.parity_err = 1'b0;
                  end
               end
            end
            FR_DATA: begin
               if (tick) begin
                  sh_d = {i_rxd, sh_q[7:1]};
                  par_d = par_q ^ i_rxd;
                  cnt_d = i_div;
                  bit_d = bit_q + 3'h1;
                  if (bit_q == LAST_BIT) begin
                     st_d = i_cfg.parity_en ? FR_PARITY : FR_STOP;
                  end
               end
            end
            FR_PARITY: begin
               if (tick) begin
                  res_d.parity_err = par_q ^ i_rxd ^ i_cfg.parity_odd;
                  cnt_d = i_div;
                  st_d = FR_STOP;
               end
            end
            FR_STOP: begin
               if (tick) begin
                  busy_d = 1'b0;
                  done_d = 1'b1;
                  res_d.data = sh_q;
                  res_d.frame_err = ~i_rxd;
                  st_d = FR_IDLE;
               end
            end
            default: st_d = FR_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         st_q <= FR_IDLE;
         cnt_q <= 16'h0000;
         bit_q <= 3'h0;
         sh_q <= 8'h00;
         par_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         res_q <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         par_q <= par_d;
         busy_q <= busy_d;
         done_q <= done_d;
         res_q <= res_d;
      end
   end

   assign o_busy = busy_q;
   assign o_done = done_q;
   assign o_res = res_q;

endmodule : urc_rx_frame

// ---- dv/urc_remote.sv ----
// Purpose: Remote serial device on the line side of the control block.
// Assumes: Bit period is i_per clocks; line idles high.
// Notes: Sends frames with chosen parity and stop values; samples the block's frames mid-bit.
`timescale 1ns/1ps
module urc_remote (
   input wire logic i_mclk,
   input wire logic [15:0] i_per,
   input wire logic i_txd,
   output logic o_rxd
);
   initial o_rxd = 1'b1;

   task automatic hold(input logic v);
      @(posedge i_mclk);
      o_rxd <= v;
      repeat (i_per - 1) @(posedge i_mclk);
   endtask : hold

   // Bad parity or a low stop only when the caller asks for it
   task automatic send(input logic [7:0] d, input logic pe, input logic pb, input logic sb);
      int i;
      hold(1'b0);
      for (i = 0; i < 8; i++) hold(d[i]);
      if (pe) hold(pb);
      hold(sb);
      hold(1'b1);
      hold(1'b1);
   endtask : send

   task automatic recv(input logic pe, output logic [8:0] d, output logic sb, output logic ok);
      int n;
      int i;
      ok = 1'b0;
      d = 9'h000;
      sb = 1'b0;
      for (n = 0; n < 400 && !ok; n++) begin
         @(posedge i_mclk);
         if (i_txd === 1'b0) ok = 1'b1;
      end
      if (ok) begin
         repeat (i_per / 2) @(posedge i_mclk);
         for (i = 0; i < 9; i++) begin
            if (i < 8 || pe) begin
               repeat (i_per) @(posedge i_mclk);
               d[i] = i_txd;
            end
         end
         repeat (i_per) @(posedge i_mclk);
         sb = i_txd;
      end
   endtask : recv
endmodule : urc_remote

// ---- dv/tb.sv ----
// Purpose: Self-checking bench of the serial control and status block.
// Assumes: Zero-wait APB slave; bit period of 8 clocks set through the baud register.
// Notes: Each scenario drives the block and judges its answers before returning.
`timescale 1ns/1ps
module tb
   import urc_pkg::*;
;
   logic clk, rst, psel, pen, pwr, pready, pslverr, rxd, txd, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   int err_count, checked;

   urc_serial_ctrl uut (.i_mclk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_rx_pin(rxd), .o_tx_pin(txd), .o_irq(irq));
   urc_remote rem (.i_mclk(clk), .i_per(16'h0008), .i_txd(txd), .o_rxd(rxd));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic wrap_up;
      if (err_count == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, x, s);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         err_count++;
         wrap_up;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask : wr

   task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 32'h0, r, e);
      chk(nm, r, x);
   endtask : rdc

   // Let the access edge's register updates land first
   task automatic irqc(input logic x);
      @(negedge clk);
      chk("irq", irq, x);
   endtask : irqc

   task automatic t_reset;
      logic [31:0] r;
      logic e;
      rdc("ctrl reset", IDX_CTRL_A, 32'h0);
      irqc(1'b0);
      rdc("irq enable", IDX_IRQ_EN, 32'h2);
      wr(IDX_CTRL_A, 32'hFF);
      rdc("ctrl write", IDX_CTRL_A, 32'h7);
      apb(1'b0, 8'h10, 32'h0, r, e);
      chk("unmapped err", e, 32'h1);
      chk("unmapped data", r, 32'h0);
   endtask : t_reset

   task automatic txone(input logic [2:0] cfg, input logic [7:0] b, input logic pe, input logic [8:0] x);
      logic [8:0] d;
      logic sb, ok;
      wr(IDX_CTRL_A, {29'h0, cfg});
      fork
         rem.recv(pe, d, sb, ok);
         wr(IDX_TXBUF, {24'h0, b});
      join
      chk("tx start", ok, 32'h1);
      // A frame that never starts would stall every later scenario
      if (!ok) wrap_up;
      chk("tx frame", d, x);
      chk("tx stop", sb, 32'h1);
      repeat (16) @(posedge clk);
   endtask : txone

   task automatic t_tx;
      wr(IDX_BAUD, 32'h7);
      wr(IDX_FUNC, 32'h5);
      wr(IDX_IRQ_EN, 32'h0);
      wr(IDX_IRQ_CLR, 32'hF);
      wr(IDX_CTRL_A, 32'h7);
      rdc("tx empty", IDX_CTRL_A, 32'h17);
      txone(3'h7, 8'hA5, 1'b1, 9'h1A5);
      irqc(1'b0);
      wr(IDX_IRQ_EN, 32'h4);
      irqc(1'b1);
      rdc("tx cmpl", IDX_CTRL_A, 32'h37);
      rdc("cmpl clear", IDX_CTRL_A, 32'h17);
      wr(IDX_IRQ_CLR, 32'h4);
      irqc(1'b0);
      txone(3'h3, 8'h01, 1'b1, 9'h101);
      txone(3'h1, 8'h3C, 1'b0, 9'h03C);
   endtask : t_tx

   task automatic t_tx_off;
      logic [8:0] d;
      logic sb, ok;
      rdc("cmpl read", IDX_CTRL_A, 32'h31);
      wr(IDX_CTRL_A, 32'h6);
      rdc("empty off", IDX_CTRL_A, 32'h16);
      fork
         rem.recv(1'b0, d, sb, ok);
         wr(IDX_TXBUF, 32'h55);
      join
      chk("tx silent", ok, 32'h0);
   endtask : t_tx_off

   task automatic t_rx;
      wr(IDX_FUNC, 32'hD);
      wr(IDX_CTRL_A, 32'h3);
      wr(IDX_IRQ_CLR, 32'hF);
      wr(IDX_IRQ_EN, 32'h1);
      fork
         rem.send(8'h3C, 1'b1, 1'b0, 1'b1);
         begin
            repeat (40) @(posedge clk);
            rdc("rx active", IDX_CTRL_A, 32'h13);
         end
      join
      rdc("rx full", IDX_CTRL_A, 32'h0B);
      irqc(1'b1);
      rdc("rx data", IDX_RXBUF, 32'h3C);
      rdc("full clear", IDX_CTRL_A, 32'h03);
      wr(IDX_IRQ_CLR, 32'h1);
      irqc(1'b0);
      wr(IDX_CTRL_A, 32'h7);
      rem.send(8'h81, 1'b1, 1'b1, 1'b1);
      rdc("odd ok", IDX_CTRL_A, 32'h0F);
      rdc("odd data", IDX_RXBUF, 32'h81);
   endtask : t_rx

   task automatic t_rx_err;
      wr(IDX_CTRL_A, 32'h3);
      rem.send(8'h11, 1'b1, 1'b1, 1'b0);
      rem.send(8'h22, 1'b1, 1'b0, 1'b1);
      rdc("rx errors", IDX_CTRL_A, 32'hEB);
      rdc("errors clear", IDX_CTRL_A, 32'h0B);
      rdc("last byte", IDX_RXBUF, 32'h22);
   endtask : t_rx_err

   task automatic t_rx_off;
      wr(IDX_CTRL_A, 32'h2);
      rem.send(8'h5A, 1'b1, 1'b0, 1'b1);
      rdc("rx off", IDX_CTRL_A, 32'h02);
   endtask : t_rx_off

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      err_count = 0;
      checked = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_tx;
      t_tx_off;
      t_rx;
      t_rx_err;
      t_rx_off;
      wrap_up;
   end
endmodule : tb
